// file: ddc_defines.svh
// Register offsets, field positions, reset values and keys of the converter register bank
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH

// ----------------------------------------
// Direct register offsets
// ----------------------------------------
`define DDC_ADDR_CODE1        8'h19
`define DDC_ADDR_CODE0        8'h1c
`define DDC_ADDR_CFG          8'h1f
`define DDC_ADDR_TRIG         8'h20

// ----------------------------------------
// Paged (PMBus) addressing
// ----------------------------------------
`define DDC_PAGE_CH0          8'h03
`define DDC_PAGE_CH1          8'h00
`define DDC_PAGE_SHARED       8'hff
`define DDC_PREG_CODE         8'h21
`define DDC_PREG_CFG          8'he3
`define DDC_PREG_TRIG         8'he4

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define DDC_CFG_RESET         16'h0fff
`define DDC_CFG_WMASK         16'hfe07
`define DDC_CFG_LATCH         15
`define DDC_CFG_LOCK          14
`define DDC_CFG_DUMP_LOC      13
`define DDC_CFG_INT_REF       12
`define DDC_CFG_VPDN0_HI      11
`define DDC_CFG_VPDN0_LO      10
`define DDC_CFG_IPDN0         9
`define DDC_CFG_VPDN1_HI      2
`define DDC_CFG_VPDN1_LO      1
`define DDC_CFG_IPDN1         0

// ----------------------------------------
// Trigger register fields
// ----------------------------------------
`define DDC_UNLOCK_KEY        4'h5
`define DDC_POR_KEY           4'ha
`define DDC_STROBE_MASK       8'hdf
`define DDC_TRIG_LOAD         7
`define DDC_TRIG_CLEAR        6
`define DDC_TRIG_DUMP         4
`define DDC_TRIG_PROTECT      3
`define DDC_TRIG_ROWRD        2
`define DDC_TRIG_PROG         1
`define DDC_TRIG_RELOAD       0

// ----------------------------------------
// Code values
// ----------------------------------------
`define DDC_CODE_ZERO         12'h000
`define DDC_CODE_MID          12'h800
`define DDC_DUMP_LOC0         8'h00
`define DDC_DUMP_LOC1         8'h01

`endif

// file: ddc_pkg.sv
// Types shared by the converter register bank
`default_nettype none

package ddc_pkg;

	typedef enum logic [2:0] {
		TGT_NONE,
		TGT_CODE0,
		TGT_CODE1,
		TGT_CFG,
		TGT_TRIG
	} ddc_target_type;

endpackage : ddc_pkg

`default_nettype wire

// file: ddc_cmp_cond.sv
// Window-comparator input synchroniser with optional latching
`timescale 1ns/10ps
`default_nettype none

module ddc_cmp_cond (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Comparator
	input  wire logic raw,
	input  wire logic latch_en,
	output var  logic cmp_out
);

	logic sync_a;
	logic sync_b;

	// ----------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= raw;
			sync_b <= sync_a;
		end
	end

	// ----------------------------------------
	// Latch or follow
	// ----------------------------------------
	// Latched trip holds until latching is turned off or reset
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp_out <= 1'b0;
		end else if (latch_en) begin
			cmp_out <= cmp_out | sync_b;
		end else begin
			cmp_out <= sync_b;
		end
	end

	AST_CMP_HOLD: assert property (@(posedge clk) disable iff (rst)
		(latch_en && cmp_out) ##1 latch_en |-> cmp_out)
		else $error("latched comparator output dropped");

	AST_CMP_FOLLOW: assert property (@(posedge clk) disable iff (rst)
		(!latch_en && !sync_b) |=> !cmp_out)
		else $error("non-latching comparator output held");

endmodule : ddc_cmp_cond

`default_nettype wire

// file: ddc_regbank.sv
// Register bank of a dual-channel converter: codes, shared configuration and trigger
`timescale 1ns/10ps
`default_nettype none
`include "ddc_defines.svh"

module ddc_regbank #(
	parameter int RES = 12
) (
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        SRST,
	// Register access port
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic        REG_PMBUS,
	input  wire logic [7:0]  REG_PAGE,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	output var  logic [15:0] REG_RDATA,
	output var  logic        REG_RVALID,
	// Per-channel settings from neighbouring registers
	input  wire logic [1:0]  SYNC_CFG,
	input  wire logic [1:0]  CLR_SEL,
	// Comparator inputs from the analog side and conditioned outputs
	input  wire logic [1:0]  CMP_RAW,
	output wire logic [1:0]  CMP_OUT,
	// Channel codes
	output wire logic [11:0] CODE_OUT0,
	output wire logic [11:0] CODE_OUT1,
	// Shared configuration
	output wire logic        LOCKED,
	output wire logic [7:0]  DUMP_ROW_ADDR,
	output wire logic        INT_REF_EN,
	output wire logic [1:0]  VOUT_PDN0,
	output wire logic [1:0]  VOUT_PDN1,
	output wire logic        IOUT_PDN0,
	output wire logic        IOUT_PDN1,
	// Action strobes
	output var  logic        POR_PULSE,
	output wire logic        LOAD_PULSE,
	output wire logic        CLEAR_PULSE,
	output wire logic        FAULT_DUMP_PULSE,
	output wire logic        PROTECT_PULSE,
	output wire logic        ROW_READ_PULSE,
	output wire logic        PROGRAM_PULSE,
	output wire logic        RELOAD_PULSE
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (RES != 12 && RES != 10) begin : g_res_check
		$error("RES must be 10 or 12");
	end

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic ddc_pkg::ddc_target_type decode(
		input logic       pm,
		input logic [7:0] page,
		input logic [7:0] addr
	);
		ddc_pkg::ddc_target_type t;
		t = ddc_pkg::TGT_NONE;
		if (!pm) begin
			case (addr)
				`DDC_ADDR_CODE0: t = ddc_pkg::TGT_CODE0;
				`DDC_ADDR_CODE1: t = ddc_pkg::TGT_CODE1;
				`DDC_ADDR_CFG:   t = ddc_pkg::TGT_CFG;
				`DDC_ADDR_TRIG:  t = ddc_pkg::TGT_TRIG;
				default:         t = ddc_pkg::TGT_NONE;
			endcase
		end else if (addr == `DDC_PREG_CODE && page == `DDC_PAGE_CH0) begin
			t = ddc_pkg::TGT_CODE0;
		end else if (addr == `DDC_PREG_CODE && page == `DDC_PAGE_CH1) begin
			t = ddc_pkg::TGT_CODE1;
		end else if (page == `DDC_PAGE_SHARED && addr == `DDC_PREG_CFG) begin
			t = ddc_pkg::TGT_CFG;
		end else if (page == `DDC_PAGE_SHARED && addr == `DDC_PREG_TRIG) begin
			t = ddc_pkg::TGT_TRIG;
		end
		return t;
	endfunction : decode

	// Low bits ignored; the 10-bit variant also drops two LSBs
	function automatic logic [11:0] fmt_code(input logic [15:0] d);
		logic [11:0] mask;
		mask = (RES == 10) ? 12'hffc : 12'hfff;
		return d[15:4] & mask;
	endfunction : fmt_code

	// ----------------------------------------
	// State
	// ----------------------------------------
	ddc_pkg::ddc_target_type tgt;
	logic [15:0] cfg;
	logic [3:0]  unlock_field;
	logic        unlock_armed;
	logic [7:0]  strobe;
	logic [11:0] pending [2];
	logic [11:0] outcode [2];
	logic        rst_all;
	logic        locked;
	logic        trig_wr;
	logic        cfg_wr;
	logic        cfg_ok;
	logic        code_wr [2];

	assign tgt     = decode(REG_PMBUS, REG_PAGE, REG_ADDR);
	assign rst_all = SRST | POR_PULSE;
	assign locked  = cfg[`DDC_CFG_LOCK];
	assign trig_wr = REG_WR && tgt == ddc_pkg::TGT_TRIG;
	assign cfg_wr  = REG_WR && tgt == ddc_pkg::TGT_CFG;
	// Locked: only password then lock-clear gets through
	assign cfg_ok  = cfg_wr && (!locked || (unlock_armed && !REG_WDATA[`DDC_CFG_LOCK]));
	assign code_wr[0] = REG_WR && !locked && tgt == ddc_pkg::TGT_CODE0;
	assign code_wr[1] = REG_WR && !locked && tgt == ddc_pkg::TGT_CODE1;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			REG_RVALID <= 1'b0;
			REG_RDATA  <= 16'h0000;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				case (tgt)
					ddc_pkg::TGT_CODE0: REG_RDATA <= {pending[0], 4'h0};
					ddc_pkg::TGT_CODE1: REG_RDATA <= {pending[1], 4'h0};
					ddc_pkg::TGT_CFG:   REG_RDATA <= cfg;
					ddc_pkg::TGT_TRIG:  REG_RDATA <= {unlock_field, 4'h0, strobe};
					default:            REG_RDATA <= 16'h0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	// Reserved bits keep their reset pattern
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			cfg <= `DDC_CFG_RESET;
		end else if (cfg_ok) begin
			cfg <= (REG_WDATA & `DDC_CFG_WMASK) | (`DDC_CFG_RESET & ~`DDC_CFG_WMASK);
		end
	end

	assign LOCKED        = locked;
	assign DUMP_ROW_ADDR = cfg[`DDC_CFG_DUMP_LOC] ? `DDC_DUMP_LOC1 : `DDC_DUMP_LOC0;
	assign INT_REF_EN    = cfg[`DDC_CFG_INT_REF];
	assign VOUT_PDN0     = cfg[`DDC_CFG_VPDN0_HI:`DDC_CFG_VPDN0_LO];
	assign VOUT_PDN1     = cfg[`DDC_CFG_VPDN1_HI:`DDC_CFG_VPDN1_LO];
	assign IOUT_PDN0     = cfg[`DDC_CFG_IPDN0];
	assign IOUT_PDN1     = cfg[`DDC_CFG_IPDN1];

	// ----------------------------------------
	// Unlock password
	// ----------------------------------------
	// Password write is accepted even while locked
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			unlock_field <= 4'h0;
			unlock_armed <= 1'b0;
		end else if (trig_wr) begin
			unlock_field <= REG_WDATA[15:12];
			unlock_armed <= REG_WDATA[15:12] == `DDC_UNLOCK_KEY;
		end else if (cfg_wr) begin
			unlock_armed <= 1'b0;
		end
	end

	// ----------------------------------------
	// Trigger strobes and software reset
	// ----------------------------------------
	// A strobe lives one cycle, then reads back zero
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			strobe <= 8'h00;
		end else if (trig_wr && !locked) begin
			strobe <= REG_WDATA[7:0] & `DDC_STROBE_MASK;
		end else begin
			strobe <= 8'h00;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			POR_PULSE <= 1'b0;
		end else begin
			POR_PULSE <= trig_wr && !locked && !POR_PULSE && REG_WDATA[11:8] == `DDC_POR_KEY;
		end
	end

	assign LOAD_PULSE       = strobe[`DDC_TRIG_LOAD];
	assign CLEAR_PULSE      = strobe[`DDC_TRIG_CLEAR];
	assign FAULT_DUMP_PULSE = strobe[`DDC_TRIG_DUMP];
	assign PROTECT_PULSE    = strobe[`DDC_TRIG_PROTECT];
	assign ROW_READ_PULSE   = strobe[`DDC_TRIG_ROWRD];
	assign PROGRAM_PULSE    = strobe[`DDC_TRIG_PROG];
	assign RELOAD_PULSE     = strobe[`DDC_TRIG_RELOAD];

	// ----------------------------------------
	// Channel codes
	// ----------------------------------------
	// Clear beats load and writes; a load in the same cycle as a write outputs the old pending code
	for (genvar ch = 0; ch < 2; ch++) begin : g_code
		always_ff @(posedge MCLK) begin
			if (rst_all) begin
				pending[ch] <= `DDC_CODE_ZERO;
				outcode[ch] <= `DDC_CODE_ZERO;
			end else if (CLEAR_PULSE) begin
				pending[ch] <= CLR_SEL[ch] ? `DDC_CODE_MID : `DDC_CODE_ZERO;
				outcode[ch] <= CLR_SEL[ch] ? `DDC_CODE_MID : `DDC_CODE_ZERO;
			end else begin
				if (LOAD_PULSE && SYNC_CFG[ch]) begin
					outcode[ch] <= pending[ch];
				end
				if (code_wr[ch]) begin
					pending[ch] <= fmt_code(REG_WDATA);
					if (!SYNC_CFG[ch]) begin
						outcode[ch] <= fmt_code(REG_WDATA);
					end
				end
			end
		end

		ddc_cmp_cond u_cmp (
			.clk      (MCLK),
			.rst      (rst_all),
			.raw      (CMP_RAW[ch]),
			.latch_en (cfg[`DDC_CFG_LATCH]),
			.cmp_out  (CMP_OUT[ch])
		);
	end

	assign CODE_OUT0 = outcode[0];
	assign CODE_OUT1 = outcode[1];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_CODE_DIRECT: assert property (@(posedge MCLK) disable iff (rst_all)
		(REG_WR && !locked && !REG_PMBUS && REG_ADDR == `DDC_ADDR_CODE0 && !SYNC_CFG[0] && !CLEAR_PULSE)
		|=> CODE_OUT0 == fmt_code($past(REG_WDATA)))
		else $error("channel 0 code write not applied");

	AST_CODE_PAGED: assert property (@(posedge MCLK) disable iff (rst_all)
		(REG_WR && !locked && REG_PMBUS && REG_PAGE == `DDC_PAGE_CH1 && REG_ADDR == `DDC_PREG_CODE && !CLEAR_PULSE)
		|=> pending[1] == fmt_code($past(REG_WDATA)))
		else $error("paged channel 1 code write lost");

	AST_CFG_PAGED: assert property (@(posedge MCLK) disable iff (rst_all)
		(REG_WR && !locked && REG_PMBUS && REG_PAGE == `DDC_PAGE_SHARED && REG_ADDR == `DDC_PREG_CFG)
		|=> cfg[`DDC_CFG_INT_REF] == $past(REG_WDATA[`DDC_CFG_INT_REF]))
		else $error("paged configuration write lost");

	AST_CFG_RESET: assert property (@(posedge MCLK)
		$past(SRST) |-> VOUT_PDN0 == 2'b11 && VOUT_PDN1 == 2'b11 && IOUT_PDN0 && IOUT_PDN1)
		else $error("power-down fields not at reset value");

	AST_LOCK_BLOCKS: assert property (@(posedge MCLK) disable iff (rst_all)
		(locked && REG_WR && tgt == ddc_pkg::TGT_CODE0 && !CLEAR_PULSE) |=> $stable(pending[0]))
		else $error("code changed while locked");

	// Password and lock-clear need not be adjacent, so these follow the armed state
	AST_UNLOCK_SEQ: assert property (@(posedge MCLK) disable iff (rst_all)
		(locked && unlock_armed && cfg_wr && !REG_WDATA[`DDC_CFG_LOCK]) |=> !LOCKED)
		else $error("unlock sequence did not clear lock");

	AST_LOCK_HOLD: assert property (@(posedge MCLK) disable iff (rst_all)
		(locked && !unlock_armed && cfg_wr) |=> LOCKED && $stable(cfg))
		else $error("configuration changed while locked");

	AST_BAD_PASSWORD: assert property (@(posedge MCLK) disable iff (rst_all)
		(trig_wr && REG_WDATA[15:12] != `DDC_UNLOCK_KEY) |=> !unlock_armed)
		else $error("wrong password armed the unlock");

	AST_ARM_SET: assert property (@(posedge MCLK) disable iff (rst_all)
		(trig_wr && REG_WDATA[15:12] == `DDC_UNLOCK_KEY) |=> unlock_armed)
		else $error("password did not arm the unlock");

	AST_ARM_SOURCE: assert property (@(posedge MCLK) disable iff (rst_all)
		$rose(unlock_armed) |-> $past(trig_wr) && $past(REG_WDATA[15:12]) == `DDC_UNLOCK_KEY)
		else $error("unlock armed without password");

	AST_POR: assert property (@(posedge MCLK) disable iff (SRST)
		(trig_wr && !locked && !POR_PULSE && REG_WDATA[11:8] == `DDC_POR_KEY)
		|=> POR_PULSE ##1 (cfg == `DDC_CFG_RESET && !POR_PULSE && strobe == 8'h00))
		else $error("software reset not performed");

	AST_STROBE_FIRE: assert property (@(posedge MCLK) disable iff (rst_all)
		(trig_wr && !locked && REG_WDATA[`DDC_TRIG_DUMP]) |=> FAULT_DUMP_PULSE)
		else $error("fault-dump strobe not issued");

	// Back-to-back trigger writes may legally re-fire a strobe
	AST_STROBE_CLEAR: assert property (@(posedge MCLK) disable iff (rst_all)
		(PROGRAM_PULSE && !trig_wr) ##1 !trig_wr |-> !PROGRAM_PULSE ##1 !PROGRAM_PULSE)
		else $error("program strobe did not self-clear");

	AST_LOAD: assert property (@(posedge MCLK) disable iff (rst_all)
		(LOAD_PULSE && !CLEAR_PULSE && SYNC_CFG[0] && !code_wr[0]) |=> CODE_OUT0 == $past(pending[0]))
		else $error("load strobe did not update channel 0");

	AST_CLEAR_MID: assert property (@(posedge MCLK) disable iff (rst_all)
		(CLEAR_PULSE && CLR_SEL[1]) |=> CODE_OUT1 == `DDC_CODE_MID && pending[1] == `DDC_CODE_MID)
		else $error("clear strobe did not set mid code");

	AST_CLEAR_ZERO: assert property (@(posedge MCLK) disable iff (rst_all)
		(CLEAR_PULSE && !CLR_SEL[0]) |=> CODE_OUT0 == `DDC_CODE_ZERO && pending[0] == `DDC_CODE_ZERO)
		else $error("clear strobe did not set zero code");

	// Only the hard reset masks this one, so a stray software reset is caught
	AST_LOCK_STROBES: assert property (@(posedge MCLK) disable iff (SRST)
		(locked && trig_wr) |=> strobe == 8'h00 && !POR_PULSE)
		else $error("trigger acted while locked");

endmodule : ddc_regbank

`default_nettype wire

// file: ddc_regbank_test.sv
// Self-checking testbench of the converter register bank
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end

module ddc_regbank_test;

	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        reg_pmbus = 1'b0;
	logic [7:0]  reg_page = 8'h00;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [1:0]  sync_cfg = 2'h0;
	logic [1:0]  clr_sel = 2'h0;
	logic [1:0]  cmp_raw = 2'h0;
	wire  [15:0] reg_rdata;
	wire         reg_rvalid;
	wire  [1:0]  cmp_out;
	wire  [11:0] code_out0;
	wire  [11:0] code_out1;
	wire         locked;
	wire  [7:0]  dump_row_addr;
	wire         int_ref_en;
	wire  [1:0]  vout_pdn0;
	wire  [1:0]  vout_pdn1;
	wire         iout_pdn0;
	wire         iout_pdn1;
	wire         por_pulse;
	wire  [6:0]  pulses;
	int          miscompares = 0;
	int          n_tests = 0;
	int          cycles = 0;

	ddc_regbank #(.RES(12)) i_ddc_regbank (
		.MCLK(mclk), .SRST(srst), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_PMBUS(reg_pmbus),
		.REG_PAGE(reg_page), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.REG_RVALID(reg_rvalid), .SYNC_CFG(sync_cfg), .CLR_SEL(clr_sel), .CMP_RAW(cmp_raw),
		.CMP_OUT(cmp_out), .CODE_OUT0(code_out0), .CODE_OUT1(code_out1), .LOCKED(locked),
		.DUMP_ROW_ADDR(dump_row_addr), .INT_REF_EN(int_ref_en), .VOUT_PDN0(vout_pdn0),
		.VOUT_PDN1(vout_pdn1), .IOUT_PDN0(iout_pdn0), .IOUT_PDN1(iout_pdn1), .POR_PULSE(por_pulse),
		.LOAD_PULSE(pulses[6]), .CLEAR_PULSE(pulses[5]), .FAULT_DUMP_PULSE(pulses[4]),
		.PROTECT_PULSE(pulses[3]), .ROW_READ_PULSE(pulses[2]), .PROGRAM_PULSE(pulses[1]),
		.RELOAD_PULSE(pulses[0])
	);

	always #20 mclk = ~mclk;

	// ----------------------------------------
	// Hang guard
	// ----------------------------------------
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : cyc

	// Returns just after the taking edge, so one-cycle pulses are visible
	task automatic wr(input logic pm, input logic [7:0] pg, input logic [7:0] ad, input logic [15:0] d);
		cyc(1);
		reg_pmbus = pm;
		reg_page = pg;
		reg_addr = ad;
		reg_wdata = d;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rdchk(input logic pm, input logic [7:0] pg, input logic [7:0] ad, input logic [15:0] e);
		cyc(1);
		reg_pmbus = pm;
		reg_page = pg;
		reg_addr = ad;
		reg_rd = 1'b1;
		cyc(1);
		reg_rd = 1'b0;
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_rdata, e)
	endtask : rdchk

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdchk(0, 8'h00, 8'h1f, 16'h0fff);
		`CHK({vout_pdn0, iout_pdn0, vout_pdn1, iout_pdn1, locked}, 7'h7e)
		rdchk(0, 8'h00, 8'h20, 16'h0000);
		rdchk(0, 8'h00, 8'h1c, 16'h0000);
	endtask : t_reset

	task automatic t_codes();
		wr(0, 8'h00, 8'h1c, 16'habcf);
		`CHK(code_out0, 12'habc)
		rdchk(1, 8'h03, 8'h21, 16'habc0);
		wr(1, 8'h00, 8'h21, 16'h1235);
		`CHK(code_out1, 12'h123)
		rdchk(0, 8'h00, 8'h19, 16'h1230);
		wr(0, 8'h00, 8'h19, 16'h4567);
		`CHK(code_out1, 12'h456)
		wr(1, 8'h03, 8'h21, 16'h89a0);
		`CHK(code_out0, 12'h89a)
		wr(0, 8'h00, 8'h30, 16'hffff);
		`CHK({code_out1, code_out0}, 24'h45689a)
		rdchk(0, 8'h00, 8'h30, 16'h0000);
	endtask : t_codes

	task automatic t_cfg();
		logic [1:0] e;
		for (int i = 0; i < 4; i++) begin
			e = i[1:0];
			wr(1, 8'hff, 8'he3, {4'h0, e, e[0], 6'h3f, e, e[0]});
			`CHK({vout_pdn0, iout_pdn0, vout_pdn1, iout_pdn1}, {e, e[0], e, e[0]})
		end
		wr(1, 8'hff, 8'he3, 16'h3fff);
		`CHK({dump_row_addr, int_ref_en}, 9'h003)
		rdchk(0, 8'h00, 8'h1f, 16'h3fff);
		wr(0, 8'h00, 8'h1f, 16'h0fff);
		`CHK({dump_row_addr, int_ref_en}, 9'h000)
	endtask : t_cfg

	task automatic t_cmp();
		wr(0, 8'h00, 8'h1f, 16'h8fff);
		cmp_raw = 2'b01;
		cyc(1);
		cmp_raw = 2'b00;
		cyc(5);
		`CHK(cmp_out, 2'b01)
		wr(0, 8'h00, 8'h1f, 16'h0fff);
		cyc(4);
		`CHK(cmp_out, 2'b00)
		cmp_raw = 2'b10;
		cyc(4);
		`CHK(cmp_out, 2'b10)
		cmp_raw = 2'b00;
		cyc(4);
		`CHK(cmp_out, 2'b00)
	endtask : t_cmp

	task automatic t_strobes();
		int pos[7] = '{7, 6, 4, 3, 2, 1, 0};
		for (int i = 0; i < 7; i++) begin
			wr(1, 8'hff, 8'he4, 16'h0001 << pos[i]);
			`CHK(pulses, 7'h40 >> i)
			cyc(1);
			`CHK(pulses, 7'h00)
			rdchk(0, 8'h00, 8'h20, 16'h0000);
		end
	endtask : t_strobes

	task automatic t_load_clear();
		wr(0, 8'h00, 8'h1c, 16'h2220);
		sync_cfg = 2'b01;
		wr(0, 8'h00, 8'h1c, 16'h5550);
		`CHK(code_out0, 12'h222)
		wr(0, 8'h00, 8'h20, 16'h0080);
		cyc(1);
		`CHK(code_out0, 12'h555)
		clr_sel = 2'b10;
		wr(0, 8'h00, 8'h20, 16'h0040);
		cyc(1);
		`CHK({code_out1, code_out0}, 24'h800000)
		rdchk(0, 8'h00, 8'h19, 16'h8000);
		sync_cfg = 2'b00;
		clr_sel = 2'b00;
	endtask : t_load_clear

	task automatic t_lock();
		wr(0, 8'h00, 8'h1f, 16'h4fff);
		`CHK(locked, 1'b1)
		wr(0, 8'h00, 8'h1c, 16'h7770);
		`CHK(code_out0, 12'h000)
		wr(0, 8'h00, 8'h20, 16'h3a40);
		`CHK({por_pulse, pulses}, 8'h00)
		wr(0, 8'h00, 8'h1f, 16'h0fff);
		`CHK(locked, 1'b1)
		wr(0, 8'h00, 8'h20, 16'h5000);
		rdchk(0, 8'h00, 8'h20, 16'h5000);
		wr(0, 8'h00, 8'h1f, 16'h0fff);
		`CHK(locked, 1'b0)
		wr(0, 8'h00, 8'h1c, 16'h7770);
		`CHK(code_out0, 12'h777)
	endtask : t_lock

	task automatic t_por();
		wr(0, 8'h00, 8'h1f, 16'h3000);
		wr(0, 8'h00, 8'h20, 16'h0b00);
		`CHK(por_pulse, 1'b0)
		wr(0, 8'h00, 8'h20, 16'h0a00);
		`CHK(por_pulse, 1'b1)
		cyc(1);
		`CHK(code_out0, 12'h000)
		rdchk(0, 8'h00, 8'h1f, 16'h0fff);
		rdchk(0, 8'h00, 8'h20, 16'h0000);
	endtask : t_por

	initial begin
		cyc(3);
		srst = 1'b0;
		t_reset();
		t_codes();
		t_cfg();
		t_cmp();
		t_strobes();
		t_load_clear();
		t_lock();
		t_por();
		end_sim();
	end

endmodule : ddc_regbank_test

`default_nettype wire
